// >>> src/sync_serial_audio_port_defines.vh
// Constants for the synchronous serial audio port
`ifndef SYNC_SERIAL_AUDIO_PORT_DEFINES_VH
`define SYNC_SERIAL_AUDIO_PORT_DEFINES_VH

// ----------------------------------------
// Data path geometry
// ----------------------------------------
`define SSAP_WORD_W 24
`define SSAP_FIFO_DEPTH 8
`define SSAP_FIFO_AW 3
`define SSAP_SLOTS 32
`define SSAP_CNT_W 5
`define SSAP_DIV_W 8

// ----------------------------------------
// Data alignment formats
// ----------------------------------------
`define SSAP_FMT_MSB 2'h0
`define SSAP_FMT_LSB 2'h1
`define SSAP_FMT_I2S 2'h2

// ----------------------------------------
// I2S operating modes
// ----------------------------------------
`define SSAP_I2S_NORMAL 2'h0
`define SSAP_I2S_MASTER 2'h1
`define SSAP_I2S_SLAVE 2'h2

// ----------------------------------------
// Frame layout and reset values
// ----------------------------------------
`define SSAP_I2S_LAST_SLOT 5'h01
`define SSAP_NORMAL_LAST_SLOT 5'h00
`define SSAP_WORD_RST 24'h000000
`define SSAP_DIV_RST 8'h00

`endif

// >>> src/ssap_fifo.v
// Eight by twenty-four bit sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_audio_port_defines.vh"

module ssap_fifo (
    input wire clk_i,
    input wire rst_i,
    input wire in_valid_i,
    input wire [`SSAP_WORD_W-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [`SSAP_WORD_W-1:0] out_data_o,
    input wire out_ready_i
);

    reg [`SSAP_WORD_W-1:0] mem [0:`SSAP_FIFO_DEPTH-1];
    reg [`SSAP_FIFO_AW:0] wr_ptr;
    reg [`SSAP_FIFO_AW:0] rd_ptr;
    wire push;
    wire pop;

    assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {`SSAP_FIFO_AW{1'b0}}};
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o = mem[rd_ptr[`SSAP_FIFO_AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= {(`SSAP_FIFO_AW+1){1'b0}};
            rd_ptr <= {(`SSAP_FIFO_AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[`SSAP_FIFO_AW-1:0]] <= in_data_i;
        end
    end

endmodule // ssap_fifo

`default_nettype wire

// >>> src/sync_serial_audio_port.v
// Full-duplex synchronous serial audio port with two channel FIFO sets
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_audio_port_defines.vh"

// Behaviour
// RULE1: Transmit and receive run at the same time
// RULE2: Sections run independently or share clock, sync
// RULE3: Clock and sync internal master or external slave
// RULE4: Normal mode moves one word per frame; code moves two words per frame in I2S format (last slot 1)
// RULE5: Network mode splits frame into thirty-two slots; code uses FRAME_SLOTS_I + 1 slots
// RULE6: Two transmit, two receive FIFOs, 8x24
// RULE7: Network mode uses FIFO sets as channels
// RULE8: I2S, LSB, MSB alignment; programmable word length
// RULE9: I2S mode master, slave or normal
// RULE10: I2S master forwards oversampling clock on pin
// RULE11: AC97 takes external clock, makes frame sync
// RULE12: Separate clock, sync selection per section
// RULE13: Programmable divider and per-direction slot masks
// RULE14: Masked slot: no drive, no pop, no push
module sync_serial_audio_port (
    input wire CORE_CLK_I,
    input wire RST_I,
    input wire OSC_CLK_I,
    input wire TX_EN_I,
    input wire RX_EN_I,
    input wire SYNC_MODE_I,
    input wire TX_CLK_INT_I,
    input wire TX_FS_INT_I,
    input wire RX_CLK_INT_I,
    input wire RX_FS_INT_I,
    input wire NET_MODE_I,
    input wire AC97_I,
    input wire [1:0] FORMAT_I,
    input wire [1:0] I2S_MODE_I,
    input wire [4:0] WORD_LEN_I,
    input wire [4:0] FRAME_SLOTS_I,
    input wire [7:0] CLK_DIV_I,
    input wire [31:0] TX_SLOT_MASK_I,
    input wire [31:0] RX_SLOT_MASK_I,
    input wire [23:0] TX0_DATA_I,
    input wire TX0_VALID_I,
    output wire TX0_READY_O,
    input wire [23:0] TX1_DATA_I,
    input wire TX1_VALID_I,
    output wire TX1_READY_O,
    output wire [23:0] RX0_DATA_O,
    output wire RX0_VALID_O,
    input wire RX0_READY_I,
    output wire [23:0] RX1_DATA_O,
    output wire RX1_VALID_O,
    input wire RX1_READY_I,
    input wire TX_BCLK_I,
    output reg TX_BCLK_O,
    output wire TX_BCLK_OE_N_O,
    input wire TX_FS_I,
    output reg TX_FS_O,
    output wire TX_FS_OE_N_O,
    output reg TX_DATA_O,
    output reg TX_DATA_OE_N_O,
    input wire RX_SERIAL_CLK_I,
    output wire RX_SERIAL_CLK_O,
    output wire RX_SERIAL_CLK_OE_N_O,
    input wire RX_FS_I,
    output reg RX_FS_O,
    output wire RX_FS_OE_N_O,
    input wire RX_DATA_I,
    output reg TX_UNDERRUN_O,
    output reg RX_OVERRUN_O
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Next {slot, bit} position of a frame counter
    function [9:0] step;
        input [4:0] bit_pos;
        input [4:0] slot_pos;
        input [4:0] wl;
        input [4:0] last;
        input start;
        begin
            if (start) begin
                step = 10'h000;
            end else if (bit_pos == wl) begin
                step = {(slot_pos == last) ? 5'h00 : slot_pos + 5'h01, 5'h00};
            end else begin
                step = {slot_pos, bit_pos + 5'h01};
            end
        end
    endfunction

    // Word bit carried at a bit position
    function [4:0] bit_index;
        input [4:0] bit_pos;
        input [4:0] wl;
        input lsb_first;
        begin
            bit_index = lsb_first ? bit_pos : wl - bit_pos;
        end
    endfunction

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire i2s_master = I2S_MODE_I == `SSAP_I2S_MASTER;
    wire i2s_slave = I2S_MODE_I == `SSAP_I2S_SLAVE;
    wire i2s_fmt = FORMAT_I == `SSAP_FMT_I2S;
    wire lsb_first = FORMAT_I == `SSAP_FMT_LSB;
    // AC97 forces external clock, internal sync
    wire tx_clk_int = AC97_I ? 1'b0 : i2s_master ? 1'b1 : i2s_slave ? 1'b0 : TX_CLK_INT_I; // RULE11 RULE9 RULE3
    wire tx_fs_int = AC97_I ? 1'b1 : i2s_master ? 1'b1 : i2s_slave ? 1'b0 : TX_FS_INT_I; // RULE11 RULE9 RULE3
    wire rx_clk_own = AC97_I ? 1'b0 : i2s_master ? 1'b1 : i2s_slave ? 1'b0 : RX_CLK_INT_I; // RULE12
    wire rx_fs_own = AC97_I ? 1'b1 : i2s_master ? 1'b1 : i2s_slave ? 1'b0 : RX_FS_INT_I; // RULE12
    wire [4:0] last_slot = NET_MODE_I ? FRAME_SLOTS_I :
        i2s_fmt ? `SSAP_I2S_LAST_SLOT : `SSAP_NORMAL_LAST_SLOT; // RULE4 RULE5

    // ----------------------------------------
    // Internal bit clock divider
    // ----------------------------------------
    reg [7:0] div_cnt;
    wire div_hit = div_cnt == CLK_DIV_I;

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            div_cnt <= `SSAP_DIV_RST;
            TX_BCLK_O <= 1'b0;
        end else if (div_hit) begin
            div_cnt <= `SSAP_DIV_RST;
            TX_BCLK_O <= ~TX_BCLK_O; // RULE13
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Bit clock edges and frame sync capture
    // ----------------------------------------
    reg tx_bclk_d;
    reg rx_bclk_d;
    reg tx_fs_prev;
    reg rx_fs_prev;
    reg tx_start;
    reg rx_start;
    wire int_rise = div_hit & ~TX_BCLK_O;
    wire int_fall = div_hit & TX_BCLK_O;
    wire tx_rise = tx_clk_int ? int_rise : TX_BCLK_I & ~tx_bclk_d; // RULE3
    wire tx_fall = tx_clk_int ? int_fall : ~TX_BCLK_I & tx_bclk_d; // RULE3
    wire rx_rise_own = rx_clk_own ? int_rise : RX_SERIAL_CLK_I & ~rx_bclk_d;
    wire rx_fall_own = rx_clk_own ? int_fall : ~RX_SERIAL_CLK_I & rx_bclk_d;
    wire rx_rise = SYNC_MODE_I ? tx_rise : rx_rise_own; // RULE2
    // I2S frames on any word select change, others on a rising sync
    wire tx_fs_ev = i2s_fmt ? TX_FS_I ^ tx_fs_prev : TX_FS_I & ~tx_fs_prev; // RULE8
    wire rx_fs_ev = i2s_fmt ? RX_FS_I ^ rx_fs_prev : RX_FS_I & ~rx_fs_prev;

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            tx_bclk_d <= 1'b0;
            rx_bclk_d <= 1'b0;
            tx_fs_prev <= 1'b0;
            rx_fs_prev <= 1'b0;
            tx_start <= 1'b0;
            rx_start <= 1'b0;
        end else begin
            tx_bclk_d <= TX_BCLK_I;
            rx_bclk_d <= RX_SERIAL_CLK_I;
            if (tx_rise) begin
                tx_fs_prev <= TX_FS_I;
                tx_start <= ~tx_fs_int & tx_fs_ev; // RULE3
            end else if (tx_fall) begin
                tx_start <= 1'b0;
            end
            if (rx_rise_own) begin
                rx_fs_prev <= RX_FS_I;
                rx_start <= ~rx_fs_own & rx_fs_ev; // RULE12
            end else if (rx_fall_own) begin
                rx_start <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Frame counters and master frame sync
    // ----------------------------------------
    reg [4:0] tx_bit;
    reg [4:0] tx_slot;
    reg [4:0] rx_bit_own;
    reg [4:0] rx_slot_own;
    wire [9:0] tx_next = step(tx_bit, tx_slot, WORD_LEN_I, last_slot, tx_start);
    wire [9:0] rx_next = step(rx_bit_own, rx_slot_own, WORD_LEN_I, last_slot, rx_start);
    wire [4:0] rx_bit = SYNC_MODE_I ? tx_bit : rx_bit_own; // RULE2
    wire [4:0] rx_slot = SYNC_MODE_I ? tx_slot : rx_slot_own; // RULE2
    // Frame started since enable; a parked section never completes a word
    reg tx_live;
    reg rx_live_own;
    wire rx_live = SYNC_MODE_I ? tx_live : rx_live_own; // RULE2

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            tx_bit <= 5'h00;
            tx_slot <= 5'h00;
            TX_FS_O <= 1'b0;
            tx_live <= 1'b0;
        end else if (~TX_EN_I) begin
            tx_bit <= WORD_LEN_I;
            tx_slot <= last_slot;
            TX_FS_O <= 1'b0;
            tx_live <= 1'b0;
        end else if (tx_fall) begin
            tx_live <= 1'b1;
            tx_bit <= tx_next[4:0];
            tx_slot <= tx_next[9:5];
            // Early sync in the last bit; I2S word select flips there
            TX_FS_O <= i2s_fmt ? (tx_next[4:0] == WORD_LEN_I) ^ tx_next[5] :
                (tx_next[4:0] == WORD_LEN_I) & (tx_next[9:5] == last_slot); // RULE4 RULE8
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rx_bit_own <= 5'h00;
            rx_slot_own <= 5'h00;
            RX_FS_O <= 1'b0;
            rx_live_own <= 1'b0;
        end else if (~RX_EN_I) begin
            rx_bit_own <= WORD_LEN_I;
            rx_slot_own <= last_slot;
            RX_FS_O <= 1'b0;
            rx_live_own <= 1'b0;
        end else if (rx_fall_own) begin
            rx_live_own <= 1'b1;
            rx_bit_own <= rx_next[4:0];
            rx_slot_own <= rx_next[9:5];
            RX_FS_O <= i2s_fmt ? (rx_next[4:0] == WORD_LEN_I) ^ rx_next[5] :
                (rx_next[4:0] == WORD_LEN_I) & (rx_next[9:5] == last_slot); // RULE12
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign TX_BCLK_OE_N_O = ~tx_clk_int; // RULE3
    assign TX_FS_OE_N_O = ~tx_fs_int; // RULE3 RULE11
    assign RX_SERIAL_CLK_O = i2s_master ? OSC_CLK_I : TX_BCLK_O; // RULE10
    assign RX_SERIAL_CLK_OE_N_O = ~(i2s_master | (rx_clk_own & ~SYNC_MODE_I)); // RULE10 RULE12
    assign RX_FS_OE_N_O = ~(rx_fs_own & ~SYNC_MODE_I); // RULE12

    // ----------------------------------------
    // FIFO sets
    // ----------------------------------------
    wire [47:0] tx_in_data = {TX1_DATA_I, TX0_DATA_I};
    wire [1:0] tx_in_valid = {TX1_VALID_I, TX0_VALID_I};
    wire [1:0] tx_in_ready;
    wire [47:0] tx_out_data;
    wire [1:0] tx_out_valid;
    wire [1:0] tx_pop;
    wire [47:0] rx_out_data;
    wire [1:0] rx_out_valid;
    wire [1:0] rx_out_ready = {RX1_READY_I, RX0_READY_I};
    wire [1:0] rx_in_ready;
    wire [1:0] rx_push;
    reg [23:0] rx_word_next;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            ssap_fifo u_tx_fifo ( // RULE6
                .clk_i(CORE_CLK_I),
                .rst_i(RST_I),
                .in_valid_i(tx_in_valid[ch]),
                .in_data_i(tx_in_data[ch*24 +: 24]),
                .in_ready_o(tx_in_ready[ch]),
                .out_valid_o(tx_out_valid[ch]),
                .out_data_o(tx_out_data[ch*24 +: 24]),
                .out_ready_i(tx_pop[ch])
            );
            ssap_fifo u_rx_fifo ( // RULE6
                .clk_i(CORE_CLK_I),
                .rst_i(RST_I),
                .in_valid_i(rx_push[ch]),
                .in_data_i(rx_word_next),
                .in_ready_o(rx_in_ready[ch]),
                .out_valid_o(rx_out_valid[ch]),
                .out_data_o(rx_out_data[ch*24 +: 24]),
                .out_ready_i(rx_out_ready[ch])
            );
        end
    endgenerate

    assign TX0_READY_O = tx_in_ready[0];
    assign TX1_READY_O = tx_in_ready[1];
    assign RX0_DATA_O = rx_out_data[23:0];
    assign RX1_DATA_O = rx_out_data[47:24];
    assign RX0_VALID_O = rx_out_valid[0];
    assign RX1_VALID_O = rx_out_valid[1];

    // ----------------------------------------
    // Transmit shifter
    // ----------------------------------------
    reg [23:0] tx_word;
    wire tx_ch = NET_MODE_I & tx_next[5]; // RULE7
    wire tx_act = ~NET_MODE_I | ~TX_SLOT_MASK_I[tx_next[9:5]]; // RULE13 RULE14
    wire tx_load = TX_EN_I & tx_fall & (tx_next[4:0] == 5'h00);
    wire tx_have = tx_out_valid[tx_ch];
    wire [23:0] tx_src = tx_ch ? tx_out_data[47:24] : tx_out_data[23:0];
    wire [23:0] tx_fresh = (tx_act & tx_have) ? tx_src : `SSAP_WORD_RST;
    wire [4:0] tx_idx = bit_index(tx_next[4:0], WORD_LEN_I, lsb_first); // RULE8

    assign tx_pop = {tx_load & tx_act & tx_ch, tx_load & tx_act & ~tx_ch}; // RULE14 RULE7

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            tx_word <= `SSAP_WORD_RST;
            TX_DATA_O <= 1'b0;
            TX_DATA_OE_N_O <= 1'b1;
            TX_UNDERRUN_O <= 1'b0;
        end else begin
            TX_UNDERRUN_O <= tx_load & tx_act & ~tx_have;
            if (~TX_EN_I) begin
                TX_DATA_OE_N_O <= 1'b1;
            end else if (tx_fall) begin // RULE1
                TX_DATA_OE_N_O <= ~tx_act; // RULE14
                if (tx_load) begin
                    tx_word <= tx_fresh; // RULE4
                    TX_DATA_O <= tx_fresh[tx_idx];
                end else begin
                    TX_DATA_O <= tx_word[tx_idx];
                end
            end
        end
    end

    // ----------------------------------------
    // Receive shifter
    // ----------------------------------------
    reg [23:0] rx_word;
    wire rx_ch = NET_MODE_I & rx_slot[0]; // RULE7
    wire rx_act = ~NET_MODE_I | ~RX_SLOT_MASK_I[rx_slot]; // RULE13 RULE14
    wire rx_take = RX_EN_I & rx_rise & rx_act & rx_live; // RULE4
    wire rx_done = rx_take & (rx_bit == WORD_LEN_I);
    wire [4:0] rx_idx = bit_index(rx_bit, WORD_LEN_I, lsb_first); // RULE8

    always @* begin
        rx_word_next = (rx_bit == 5'h00) ? `SSAP_WORD_RST : rx_word;
        rx_word_next[rx_idx] = RX_DATA_I;
    end

    assign rx_push = {rx_done & rx_ch, rx_done & ~rx_ch}; // RULE14 RULE7

    always @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rx_word <= `SSAP_WORD_RST;
            RX_OVERRUN_O <= 1'b0;
        end else begin
            RX_OVERRUN_O <= rx_done & ~rx_in_ready[rx_ch];
            if (rx_take) begin // RULE1
                rx_word <= rx_word_next;
            end
        end
    end

endmodule // sync_serial_audio_port

`default_nettype wire

// >>> testbench/ssap_checker_properties.sv
// Port-level assertions for the synchronous serial audio port
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_audio_port_defines.vh"
module ssap_checker (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic OSC_CLK_I,
    input wire logic TX_EN_I,
    input wire logic SYNC_MODE_I,
    input wire logic TX_CLK_INT_I,
    input wire logic TX_FS_INT_I,
    input wire logic RX_FS_INT_I,
    input wire logic AC97_I,
    input wire logic [1:0] I2S_MODE_I,
    input wire logic [7:0] CLK_DIV_I,
    input wire logic TX0_READY_O,
    input wire logic TX1_READY_O,
    input wire logic RX0_VALID_O,
    input wire logic RX1_VALID_O,
    input wire logic TX_BCLK_O,
    input wire logic TX_BCLK_OE_N_O,
    input wire logic TX_FS_OE_N_O,
    input wire logic TX_DATA_OE_N_O,
    input wire logic RX_SERIAL_CLK_O,
    input wire logic RX_SERIAL_CLK_OE_N_O,
    input wire logic RX_FS_OE_N_O,
    input wire logic TX_UNDERRUN_O,
    input wire logic RX_OVERRUN_O
);
    // ----------------------------------------
    // Bit clock half-period counter
    // ----------------------------------------
    logic [7:0] half_cnt;
    logic last_bclk;
    logic primed;
    wire normal_cfg = !AC97_I && I2S_MODE_I == `SSAP_I2S_NORMAL;
    always_ff @(posedge CORE_CLK_I) begin
        last_bclk <= TX_BCLK_O;
        if (RST_I || !TX_EN_I || TX_BCLK_OE_N_O) begin
            half_cnt <= 8'h00;
            primed <= 1'h0;
        end else if (TX_BCLK_O != last_bclk) begin
            half_cnt <= 8'h00;
            primed <= 1'h1;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    clk_div_period_a: assert property (primed && TX_EN_I && !TX_BCLK_OE_N_O && TX_BCLK_O != last_bclk
        |-> half_cnt == CLK_DIV_I) else $error("bit clock half period wrong");
    osc_forward_a: assert property (I2S_MODE_I == `SSAP_I2S_MASTER |-> RX_SERIAL_CLK_O == OSC_CLK_I)
        else $error("oversampling clock not forwarded");
    i2s_master_pins_a: assert property (I2S_MODE_I == `SSAP_I2S_MASTER && !AC97_I
        |-> !TX_BCLK_OE_N_O && !TX_FS_OE_N_O && !RX_SERIAL_CLK_OE_N_O) else $error("master pins not driven");
    ac97_pins_a: assert property (AC97_I && I2S_MODE_I == `SSAP_I2S_NORMAL
        |-> TX_BCLK_OE_N_O && !TX_FS_OE_N_O) else $error("ac97 clock or sync direction wrong");
    tx_clk_select_a: assert property (normal_cfg |-> TX_BCLK_OE_N_O == !TX_CLK_INT_I)
        else $error("bit clock direction wrong");
    fs_select_a: assert property (normal_cfg |-> TX_FS_OE_N_O == !TX_FS_INT_I
        && (SYNC_MODE_I || RX_FS_OE_N_O == !RX_FS_INT_I)) else $error("sync direction wrong");
    sync_share_a: assert property (SYNC_MODE_I |-> RX_FS_OE_N_O)
        else $error("receive sync driven in shared mode");
    reset_clear_a: assert property (disable iff (1'h0) RST_I |=> TX_DATA_OE_N_O && !TX_UNDERRUN_O
        && !RX_OVERRUN_O && TX0_READY_O && TX1_READY_O && !RX0_VALID_O && !RX1_VALID_O)
        else $error("state not cleared by reset");
    underrun_pulse_a: assert property (TX_UNDERRUN_O |=> !TX_UNDERRUN_O)
        else $error("underrun pulse too long");
    idle_release_a: assert property (!TX_EN_I ##1 !TX_EN_I |-> TX_DATA_OE_N_O)
        else $error("data pin driven while disabled");
endmodule // ssap_checker
bind sync_serial_audio_port ssap_checker u_checker (.*);
`default_nettype wire

// >>> testbench/codec_partner.sv
// External codec model: looped-back data, external bit clock, pin resolution
`timescale 1ns/1ps
`default_nettype none
module codec_partner (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic data_i,
    input wire logic data_oe_n_i,
    input wire logic bclk_i,
    input wire logic bclk_oe_n_i,
    input wire logic fs_i,
    input wire logic fs_oe_n_i,
    output logic data_o,
    output logic bclk_o,
    output logic fs_o
);
    logic [1:0] div = 2'h0;
    logic ext = 1'h0;
    // Bit clock only runs while external clocking is in use
    always @(posedge clk_i) begin
        if (!run_i) begin
            div <= 2'h0;
            ext <= 1'h0;
        end else if (div == 2'h2) begin
            div <= 2'h0;
            ext <= ~ext;
        end else begin
            div <= div + 2'h1;
        end
    end
    assign bclk_o = bclk_oe_n_i ? ext : bclk_i;
    assign fs_o = fs_oe_n_i ? 1'h0 : fs_i;
    // Released data line is pulled up; only driven slots loop back
    assign data_o = data_oe_n_i ? 1'h1 : data_i;
endmodule // codec_partner
`default_nettype wire

// >>> testbench/sync_serial_audio_port_bench.sv
// Self-checking loopback testbench for the synchronous serial audio port
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_audio_port_defines.vh"
module sync_serial_audio_port_bench;
    logic CORE_CLK_I = 1'h0, RST_I = 1'h1, OSC_CLK_I = 1'h0, TX_EN_I = 1'h0, RX_EN_I = 1'h0, SYNC_MODE_I = 1'h1;
    logic TX_CLK_INT_I = 1'h1, TX_FS_INT_I = 1'h1, RX_CLK_INT_I = 1'h1, RX_FS_INT_I = 1'h1;
    logic NET_MODE_I = 1'h0, AC97_I = 1'h0;
    logic [1:0] FORMAT_I = 2'h0, I2S_MODE_I = 2'h0;
    logic [4:0] WORD_LEN_I = 5'h07, FRAME_SLOTS_I = 5'h00;
    logic [7:0] CLK_DIV_I = 8'h01;
    logic [31:0] TX_SLOT_MASK_I = 32'h0, RX_SLOT_MASK_I = 32'h0;
    logic [23:0] TX0_DATA_I = 24'h0, TX1_DATA_I = 24'h0;
    logic TX0_VALID_I = 1'h0, TX1_VALID_I = 1'h0, RX0_READY_I = 1'h1, RX1_READY_I = 1'h1;
    logic RX_SERIAL_CLK_I = 1'h0, RX_FS_I = 1'h0;
    wire logic [23:0] RX0_DATA_O, RX1_DATA_O;
    wire logic TX0_READY_O, TX1_READY_O, RX0_VALID_O, RX1_VALID_O, TX_BCLK_O, TX_BCLK_OE_N_O, TX_FS_O;
    wire logic TX_FS_OE_N_O, TX_DATA_O, TX_DATA_OE_N_O, RX_SERIAL_CLK_O, RX_SERIAL_CLK_OE_N_O, RX_FS_O;
    wire logic RX_FS_OE_N_O, TX_UNDERRUN_O, RX_OVERRUN_O, TX_BCLK_I, TX_FS_I, RX_DATA_I;
    logic [23:0] exp0[$], exp1[$];
    logic ebits[$];
    logic prev_bclk = 1'h0;
    logic saw_underrun = 1'h0;
    logic slotpos = 1'h0;
    int bitpos = 0;
    int failures = 0, total_checks = 0;

    sync_serial_audio_port u_dut (.*);
    codec_partner u_partner (.clk_i(CORE_CLK_I), .run_i(TX_BCLK_OE_N_O), .data_i(TX_DATA_O),
        .data_oe_n_i(TX_DATA_OE_N_O),
        .bclk_i(TX_BCLK_O), .bclk_oe_n_i(TX_BCLK_OE_N_O), .fs_i(TX_FS_O), .fs_oe_n_i(TX_FS_OE_N_O),
        .data_o(RX_DATA_I), .bclk_o(TX_BCLK_I), .fs_o(TX_FS_I));

    initial forever #10 CORE_CLK_I = ~CORE_CLK_I;
    initial forever #7 OSC_CLK_I = ~OSC_CLK_I;
    // ----------------------------------------
    // Reference comparison
    // ----------------------------------------
    task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Words are popped at the next rising edge, so each is seen once here
    always @(negedge CORE_CLK_I) begin
        prev_bclk <= TX_BCLK_I;
        if (RX0_VALID_O === 1'h1) check("rx0", RX0_DATA_O, exp0.size() ? exp0.pop_front() : 24'h0);
        if (RX1_VALID_O === 1'h1) begin
            check("rx1 channel", NET_MODE_I, 1'h1);
            check("rx1", RX1_DATA_O, exp1.size() ? exp1.pop_front() : 24'h0);
        end
        if (TX_UNDERRUN_O === 1'h1) saw_underrun = 1'h1;
        if (RX_OVERRUN_O !== 1'h0) check("overrun", RX_OVERRUN_O, 1'h0);
        if (TX_DATA_OE_N_O !== 1'h0) begin
            bitpos = 0;
            slotpos = 1'h0;
        end else if (!NET_MODE_I && TX_BCLK_I && !prev_bclk) begin
            check("serial bit", TX_DATA_O, ebits.size() ? ebits.pop_front() : 1'h0);
            check("frame sync", TX_FS_O, (bitpos == WORD_LEN_I) ^ slotpos);
            if (bitpos == WORD_LEN_I && FORMAT_I == `SSAP_FMT_I2S) slotpos = !slotpos;
            bitpos = bitpos == WORD_LEN_I ? 0 : bitpos + 1;
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task push(input logic ch, input logic [23:0] w);
        int b;
        @(negedge CORE_CLK_I);
        TX0_VALID_I = !ch;
        TX1_VALID_I = ch;
        if (ch) TX1_DATA_I = w;
        else TX0_DATA_I = w;
        if (ch) exp1.push_back(w & ({24{1'h1}} >> (5'h17 - WORD_LEN_I)));
        else exp0.push_back(w & ({24{1'h1}} >> (5'h17 - WORD_LEN_I)));
        for (b = 0; b <= WORD_LEN_I && !ch && !NET_MODE_I; b++)
            ebits.push_back(FORMAT_I == `SSAP_FMT_LSB ? w[b] : w[WORD_LEN_I - b]);
        @(posedge CORE_CLK_I);
    endtask

    task run(input logic [1:0] fmt, input logic [1:0] i2s, input logic [4:0] wl, input logic net,
             input logic ac, input logic [4:0] slots, input logic [31:0] mask, input int n0, input int n1);
        int i;
        @(negedge CORE_CLK_I);
        RST_I = 1'h1;
        FORMAT_I = fmt;
        I2S_MODE_I = i2s;
        WORD_LEN_I = wl;
        NET_MODE_I = net;
        AC97_I = ac;
        FRAME_SLOTS_I = slots;
        TX_SLOT_MASK_I = mask;
        RX_SLOT_MASK_I = mask;
        CLK_DIV_I = 8'h01 + 8'($urandom_range(2));
        SYNC_MODE_I = ac || fmt != `SSAP_FMT_LSB;
        TX_CLK_INT_I = SYNC_MODE_I ? 1'($urandom) : 1'h1;
        TX_FS_INT_I = 1'($urandom);
        RX_CLK_INT_I = SYNC_MODE_I ? 1'($urandom) : 1'h1;
        RX_FS_INT_I = SYNC_MODE_I ? 1'($urandom) : 1'h1;
        repeat (4) @(negedge CORE_CLK_I);
        RST_I = 1'h0;
        saw_underrun = 1'h0;
        check("tx ready", TX0_READY_O, 1'h1);
        check("data release", TX_DATA_OE_N_O, 1'h1);
        for (i = 0; i < n0 + n1; i++) push(i >= n0, 24'($urandom));
        @(negedge CORE_CLK_I);
        if (n0 == 8) check("fifo full", TX0_READY_O, 1'h0);
        TX0_VALID_I = 1'h0;
        TX1_VALID_I = 1'h0;
        TX_EN_I = 1'h1;
        RX_EN_I = 1'h1;
        for (i = 0; i < 20000 && (exp0.size() || exp1.size() || ebits.size()); i++) @(negedge CORE_CLK_I);
        check("drained", 24'(exp0.size() + exp1.size() + ebits.size()), 24'h0);
        repeat (300) @(negedge CORE_CLK_I);
        check("underrun seen", saw_underrun, 1'h1);
        TX_EN_I = 1'h0;
        RX_EN_I = 1'h0;
        $display("test done format %0d i2s %0d network %0d ac97 %0d", fmt, i2s, net, ac);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #600000;
        failures++;
        summarize;
    end

    initial begin
        void'($urandom(70));
        run(`SSAP_FMT_MSB, `SSAP_I2S_NORMAL, 5'h07, 1'h0, 1'h0, 5'h00, 32'h0, 8, 0);
        run(`SSAP_FMT_LSB, `SSAP_I2S_NORMAL, 5'h17, 1'h0, 1'h0, 5'h00, 32'h0, 3, 0);
        run(`SSAP_FMT_I2S, `SSAP_I2S_MASTER, 5'h0f, 1'h0, 1'h0, 5'h00, 32'h0, 4, 0);
        run(`SSAP_FMT_MSB, `SSAP_I2S_NORMAL, 5'h0f, 1'h0, 1'h1, 5'h00, 32'h0, 3, 0);
        run(`SSAP_FMT_MSB, `SSAP_I2S_SLAVE, 5'h09, 1'h0, 1'h0, 5'h00, 32'h0, 2, 0);
        run(`SSAP_FMT_MSB, `SSAP_I2S_NORMAL, 5'h0b, 1'h1, 1'h0, 5'h03, 32'h4, 2, 4);
        run(`SSAP_FMT_LSB, `SSAP_I2S_NORMAL, 5'h07, 1'h1, 1'h0, 5'h1f, 32'h7ffffffc, 2, 4);
        summarize;
    end
endmodule // sync_serial_audio_port_bench
`default_nettype wire
